/* hw/icc_pkg.sv */
// Shared constants for the input capture channel: register map, field
// positions, reset values and the capture mode encoding.
// Assumes a 16-bit register port with an 8-bit byte-free word address.
package icc_pkg;

  // Register port widths
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 16;
  localparam int TB_W         = 16;

  // Channel count and per-channel address window
  localparam int MAX_CHANNELS = 8;
  localparam int CHAN_SEL_W   = 6;
  localparam int REG_IDX_W    = 2;

  // Register indices inside one channel window
  localparam logic [REG_IDX_W-1:0] CTRL_OFF = 2'h0;
  localparam logic [REG_IDX_W-1:0] BUF_OFF  = 2'h1;
  localparam logic [REG_IDX_W-1:0] STAT_OFF = 2'h2;
  localparam logic [REG_IDX_W-1:0] MASK_OFF = 2'h3;

  // Control register field positions
  localparam int IDLE_HALT_BIT = 13;
  localparam int TB_SEL_BIT    = 7;
  localparam int CPI_LSB       = 5;
  localparam int CPI_W         = 2;
  localparam int OVF_BIT       = 4;
  localparam int BNE_BIT       = 3;
  localparam int MODE_LSB      = 0;
  localparam int MODE_W        = 3;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

  // Interrupt status and mask layout
  localparam int IRQ_W        = 3;
  localparam int IRQ_CAPT_BIT = 0;
  localparam int IRQ_OVF_BIT  = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Capture buffer and prescaler
  localparam int FIFO_DEPTH = 4;
  localparam int PRESC_W    = 4;
  localparam logic [PRESC_W-1:0] PRESC4_LAST  = 4'h3;
  localparam logic [PRESC_W-1:0] PRESC16_LAST = 4'hf;

  // Capture mode encoding
  typedef enum logic [MODE_W-1:0] {
    MODE_OFF    = 3'b000,
    MODE_BOTH   = 3'b001,
    MODE_FALL   = 3'b010,
    MODE_RISE   = 3'b011,
    MODE_DIV4   = 3'b100,
    MODE_DIV16  = 3'b101,
    MODE_UNUSED = 3'b110,
    MODE_WAKE   = 3'b111
  } icc_mode_t;

endpackage

/* hw/icc_fifo_if.sv */
// Connection between the capture channel and its capture buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface icc_fifo_if #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
);
  logic                           push_valid;
  logic                           push_ready;
  logic [WIDTH-1:0]               push_data;
  logic                           pop;
  logic [WIDTH-1:0]               pop_data;
  logic [$clog2(DEPTH+1)-1:0]     level;

  modport store (input push_valid, push_data, pop, output push_ready, pop_data, level);
  modport user  (output push_valid, push_data, pop, input push_ready, pop_data, level);
endinterface

/* hw/icc_fifo.sv */
// Capture buffer: first in, first out, pop shows the oldest word.
// Assumes pop is only raised while level is non-zero.
`timescale 1ns/1ns
module icc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic  clk_sys_in,
  input  wire logic  reset_in,
  // Buffer port
  icc_fifo_if.store  fif
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH-1);
  localparam logic [LW-1:0] FULL = LW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [LW-1:0]    level;
  logic             do_pop;
  logic             do_push;

  // A pop in the same cycle frees the slot, so a full buffer still takes it
  assign do_pop          = fif.pop && (level != '0);
  assign fif.push_ready  = (level != FULL) || do_pop;
  assign do_push         = fif.push_valid && fif.push_ready;
  assign fif.pop_data    = mem[rd_ptr];
  assign fif.level       = level;

  always_ff @(posedge clk_sys_in) begin
    if (do_push) begin
      mem[wr_ptr] <= fif.push_data;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        level <= level + 1'b1;
      end else if (do_pop && !do_push) begin
        level <= level - 1'b1;
      end
    end
  end

  a_fifo_bound: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    level <= FULL) else $error("Buffer level beyond depth");
  a_fifo_order: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (do_push && level == '0 && !do_pop) |=> (fif.pop_data == $past(fif.push_data)))
    else $error("Oldest word not shown first");
endmodule

/* hw/icc_capture_channel.sv */
// Input capture channel: control, edge detection, capture buffer, interrupts.
// Assumes a plain register port on clk_sys_in, timer counts on the same clock
// and an asynchronous capture pin; up to eight instances share one port.
//
// What this block does
// - Record selected 16-bit timer count per event
// - Bit 7 chooses timer A, else B
// - Four-word buffer, read in capture order
// - Interrupt after one to four captures
// - Every-edge mode ignores captures-per-interrupt
// - Modes 011/010/001: rising, falling, both edges
// - Modes 100/101: every 4th/16th rising edge
// - Modes 000 and 110 keep channel off
// - Mode 111: rising-edge wake interrupt only
// - Overflow flag, bit 4, read-only
// - Buffer-not-empty flag, bit 3, read-only
// - Bit 13 halts channel during Idle
// - Capture event wakes from Sleep, Idle
// - Bits 15-14 and 12-8 read zero
// - Up to eight independent channels
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ns
module icc_capture_channel #(
  parameter int CHAN_INDEX = 0,
  parameter int FIFO_DEPTH = icc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        reset_in,
  // Register port
  input  wire logic [icc_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [icc_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                        reg_write_in,
  input  wire logic                        reg_read_in,
  output logic      [icc_pkg::DATA_W-1:0]  reg_rdata_out,
  // Capture pin and time bases
  input  wire logic                        capture_input_pin_in,
  input  wire logic [icc_pkg::TB_W-1:0]    timebase_a_count_in,
  input  wire logic [icc_pkg::TB_W-1:0]    timebase_b_count_in,
  // Power state
  input  wire logic                        cpu_sleep_in,
  input  wire logic                        cpu_idle_in,
  // Interrupt and wake-up
  output logic                             irq_out,
  output logic                             wake_out
);
  localparam int LW = $clog2(FIFO_DEPTH+1);
  localparam logic [LW-1:0] LEVEL_ONE  = LW'(1);
  localparam logic [LW-1:0] LEVEL_FULL = LW'(FIFO_DEPTH);
  localparam logic [icc_pkg::CHAN_SEL_W-1:0] CHAN_SEL =
    icc_pkg::CHAN_SEL_W'(CHAN_INDEX % icc_pkg::MAX_CHANNELS);

  // Control fields
  logic                               idle_halt_select;
  logic                               timebase_select;
  logic [icc_pkg::CPI_W-1:0]          captures_per_interrupt;
  icc_pkg::icc_mode_t                 capture_mode_select;
  logic                               capture_overflow_flag;
  logic                               buffer_not_empty_flag;

  // Pin synchroniser and edges
  logic                               pin_meta;
  logic                               pin_sync;
  logic                               pin_prev;
  logic                               rise;
  logic                               fall;

  // Event logic
  logic [icc_pkg::PRESC_W-1:0]        presc_cnt;
  logic [icc_pkg::CPI_W-1:0]          cpi_cnt;
  logic                               edge_evt;
  logic                               active;
  logic                               capture_evt;
  logic                               irq_capt_evt;
  logic                               wake_evt;
  logic                               low_power;

  // Register port decode
  logic                               hit;
  logic [icc_pkg::REG_IDX_W-1:0]      idx;
  logic                               ctrl_wr;
  logic                               mask_wr;
  logic                               stat_rd;
  logic                               buf_rd;
  logic [icc_pkg::IRQ_W-1:0]          irq_status;
  logic [icc_pkg::IRQ_W-1:0]          irq_mask;
  logic [icc_pkg::IRQ_W-1:0]          next_irq_status;
  logic [icc_pkg::DATA_W-1:0]         ctrl_view;
  logic [icc_pkg::DATA_W-1:0]         next_rdata;

  icc_fifo_if #(.WIDTH(icc_pkg::TB_W), .DEPTH(FIFO_DEPTH)) fif ();

  icc_fifo #(
    .WIDTH (icc_pkg::TB_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .fif        (fif.store)
  );

  assign hit     = (reg_addr_in[icc_pkg::ADDR_W-1:icc_pkg::REG_IDX_W] == CHAN_SEL);
  assign idx     = reg_addr_in[icc_pkg::REG_IDX_W-1:0];
  assign ctrl_wr = reg_write_in && hit && (idx == icc_pkg::CTRL_OFF);
  assign mask_wr = reg_write_in && hit && (idx == icc_pkg::MASK_OFF);
  assign stat_rd = reg_read_in && hit && (idx == icc_pkg::STAT_OFF);
  assign buf_rd  = reg_read_in && hit && (idx == icc_pkg::BUF_OFF);

  // Control register; flag bits are never written by software
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      idle_halt_select       <= icc_pkg::CTRL_RESET[icc_pkg::IDLE_HALT_BIT];
      timebase_select        <= icc_pkg::CTRL_RESET[icc_pkg::TB_SEL_BIT];
      captures_per_interrupt <= icc_pkg::CTRL_RESET[icc_pkg::CPI_LSB +: icc_pkg::CPI_W];
      capture_mode_select    <= icc_pkg::MODE_OFF;
    end else if (ctrl_wr) begin
      idle_halt_select       <= reg_wdata_in[icc_pkg::IDLE_HALT_BIT];
      timebase_select        <= reg_wdata_in[icc_pkg::TB_SEL_BIT];
      captures_per_interrupt <= reg_wdata_in[icc_pkg::CPI_LSB +: icc_pkg::CPI_W];
      capture_mode_select    <=
        icc_pkg::icc_mode_t'(reg_wdata_in[icc_pkg::MODE_LSB +: icc_pkg::MODE_W]);
    end
  end

  // Pin passes two flops before any edge logic looks at it
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= capture_input_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign rise      = pin_sync && !pin_prev;
  assign fall      = !pin_sync && pin_prev;
  assign low_power = cpu_sleep_in || cpu_idle_in;

  assign active = (capture_mode_select != icc_pkg::MODE_OFF) &&
                  (capture_mode_select != icc_pkg::MODE_UNUSED) &&
                  (capture_mode_select != icc_pkg::MODE_WAKE) &&
                  !(cpu_idle_in && idle_halt_select);

  always_comb begin
    case (capture_mode_select)
      icc_pkg::MODE_BOTH:  edge_evt = rise || fall;
      icc_pkg::MODE_FALL:  edge_evt = fall;
      icc_pkg::MODE_RISE:  edge_evt = rise;
      icc_pkg::MODE_DIV4:  edge_evt = rise && (presc_cnt == icc_pkg::PRESC4_LAST);
      icc_pkg::MODE_DIV16: edge_evt = rise && (presc_cnt == icc_pkg::PRESC16_LAST);
      default:             edge_evt = 1'b0;
    endcase
  end

  assign capture_evt = active && edge_evt;

  // edge prescaler
  // Restarts on any control write so a new ratio counts from zero
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      presc_cnt <= '0;
    end else if (ctrl_wr || !active) begin
      presc_cnt <= '0;
    end else if (rise && (capture_mode_select == icc_pkg::MODE_DIV4 ||
                          capture_mode_select == icc_pkg::MODE_DIV16)) begin
      presc_cnt <= edge_evt ? '0 : presc_cnt + 1'b1;
    end
  end

  // time base choice
  // Count is taken two to three cycles after the pin edge, after the synchroniser
  assign fif.push_valid = capture_evt;
  assign fif.push_data  = timebase_select ? timebase_a_count_in : timebase_b_count_in;

  assign fif.pop = buf_rd && (fif.level != '0);

  // hardware owns the flag
  // A refused capture is dropped; the stored words stay intact
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      capture_overflow_flag <= 1'b0;
    end else if (capture_evt && !fif.push_ready) begin
      capture_overflow_flag <= 1'b1;
    end else if (fif.pop && fif.level == LEVEL_ONE && !capture_evt) begin
      capture_overflow_flag <= 1'b0;
    end
  end

  assign buffer_not_empty_flag = (fif.level != '0);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cpi_cnt <= '0;
    end else if (ctrl_wr || !active) begin
      cpi_cnt <= '0;
    end else if (capture_evt) begin
      cpi_cnt <= irq_capt_evt ? '0 : cpi_cnt + 1'b1;
    end
  end

  assign irq_capt_evt = capture_evt &&
                        ((capture_mode_select == icc_pkg::MODE_BOTH) ||
                         (cpi_cnt == captures_per_interrupt));

  assign wake_evt = (capture_mode_select == icc_pkg::MODE_WAKE) && low_power && rise;

  // Sticky status: the set wins over the clearing read
  always_comb begin
    next_irq_status = stat_rd ? icc_pkg::IRQ_RESET : irq_status;
    if (irq_capt_evt) begin
      next_irq_status[icc_pkg::IRQ_CAPT_BIT] = 1'b1;
    end
    if (capture_evt && !fif.push_ready) begin
      next_irq_status[icc_pkg::IRQ_OVF_BIT] = 1'b1;
    end
    if (wake_evt) begin
      next_irq_status[icc_pkg::IRQ_WAKE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      irq_status <= icc_pkg::IRQ_RESET;
      irq_mask   <= icc_pkg::IRQ_RESET;
      irq_out    <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (mask_wr) begin
        irq_mask <= reg_wdata_in[icc_pkg::IRQ_W-1:0];
      end
      irq_out <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= low_power && (capture_evt || wake_evt);
    end
  end

  always_comb begin
    ctrl_view                                          = '0;
    ctrl_view[icc_pkg::IDLE_HALT_BIT]                  = idle_halt_select;
    ctrl_view[icc_pkg::TB_SEL_BIT]                     = timebase_select;
    ctrl_view[icc_pkg::CPI_LSB +: icc_pkg::CPI_W]      = captures_per_interrupt;
    ctrl_view[icc_pkg::OVF_BIT]                        = capture_overflow_flag;
    ctrl_view[icc_pkg::BNE_BIT]                        = buffer_not_empty_flag;
    ctrl_view[icc_pkg::MODE_LSB +: icc_pkg::MODE_W]    = capture_mode_select;
  end

  // Read mux; misses return zero so eight channels may OR their data
  always_comb begin
    next_rdata = '0;
    if (reg_read_in && hit) begin
      case (idx)
        icc_pkg::CTRL_OFF: next_rdata = ctrl_view;
        icc_pkg::BUF_OFF:  next_rdata = buffer_not_empty_flag ? fif.pop_data : '0;
        icc_pkg::STAT_OFF: next_rdata = icc_pkg::DATA_W'(irq_status);
        icc_pkg::MASK_OFF: next_rdata = icc_pkg::DATA_W'(irq_mask);
        default:           next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  sequence s_ctrl_read;
    reg_read_in && hit && (idx == icc_pkg::CTRL_OFF);
  endsequence

  sequence s_rise_seen;
    pin_sync && !pin_prev;
  endsequence

  sequence s_full_capture;
    capture_evt && (fif.level == LEVEL_FULL) && !fif.pop;
  endsequence

  a_rise_capture: assert property (
    (capture_mode_select == icc_pkg::MODE_RISE && active) ##0 s_rise_seen |-> capture_evt)
    else $error("Rising edge not captured");
  a_fall_ignored: assert property (
    (capture_mode_select == icc_pkg::MODE_RISE) && fall |-> !capture_evt)
    else $error("Falling edge captured in rising mode");
  a_mode_off: assert property (
    (capture_mode_select == icc_pkg::MODE_OFF ||
     capture_mode_select == icc_pkg::MODE_UNUSED) |-> !fif.push_valid)
    else $error("Disabled channel captured");
  a_wake_mode: assert property (
    (capture_mode_select == icc_pkg::MODE_WAKE) ##0 s_rise_seen ##0 low_power
    |=> irq_status[icc_pkg::IRQ_WAKE_BIT] && wake_out && $stable(fif.level))
    else $error("Wake mode edge mishandled");
  a_idle_halt: assert property (
    cpu_idle_in && idle_halt_select |-> !fif.push_valid)
    else $error("Capture while halted in Idle");
  a_every_edge: assert property (
    capture_evt && capture_mode_select == icc_pkg::MODE_BOTH && !stat_rd
    |=> irq_status[icc_pkg::IRQ_CAPT_BIT])
    else $error("Every-edge mode missed interrupt");
  a_ovf_set: assert property (
    s_full_capture |=> capture_overflow_flag && fif.level == LEVEL_FULL)
    else $error("Overflow not flagged");
  a_bne_read: assert property (
    s_ctrl_read |=> reg_rdata_out[icc_pkg::BNE_BIT] == ($past(fif.level) != '0))
    else $error("Not-empty flag wrong");
  a_reserved_zero: assert property (
    s_ctrl_read |=> reg_rdata_out[15:14] == 2'h0 && reg_rdata_out[12:8] == 5'h00)
    else $error("Unimplemented bits not zero");
  a_pick_timer: assert property (
    capture_evt && fif.level == '0 && !fif.pop
    |=> fif.pop_data == ($past(timebase_select) ? $past(timebase_a_count_in) :
                                                  $past(timebase_b_count_in)))
    else $error("Wrong time base stored");
  a_wake_out: assert property (
    capture_evt && low_power |=> wake_out)
    else $error("No wake on capture");
endmodule

/* testbench/icc_pin_model.sv */
// Far-side model: an external logic signal on the capture pin.
// Assumes the caller sequences edges; the level holds between edges.
`timescale 1ns/1ns
module icc_pin_model (
  // Clock
  input  wire logic clk_sys_in,
  // Capture pin
  output logic      pin_out
);
  initial pin_out = 1'b0;

  // New level one edge later, held so the two-flop synchroniser sees it
  task automatic drive(input logic level, input int hold);
    @(posedge clk_sys_in);
    pin_out <= level;
    repeat (hold) @(posedge clk_sys_in);
  endtask
endmodule

/* testbench/input_capture_channel_bench.sv */
// Self-checking bench for one capture channel at channel index 2.
// Assumes the register map and status layout of icc_pkg.
`timescale 1ns/1ns
module input_capture_channel_bench;
  localparam int CH = 2;
  logic        clk_sys_in, reset_in, reg_write_in, reg_read_in;
  logic        cpu_sleep_in, cpu_idle_in, pin, irq, wake, wake_seen;
  logic [7:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, rdata, ta, tb, v;
  logic [2:0]  cm;
  logic        ts;
  logic [15:0] q[$];
  int          fail_count, check_count, seed, cyc, rcnt, n;

  icc_pin_model pin_drv (.clk_sys_in(clk_sys_in), .pin_out(pin));

  icc_capture_channel #(.CHAN_INDEX(CH)) u_icc_capture_channel (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(rdata), .capture_input_pin_in(pin),
    .timebase_a_count_in(ta), .timebase_b_count_in(tb), .cpu_sleep_in(cpu_sleep_in),
    .cpu_idle_in(cpu_idle_in), .irq_out(irq), .wake_out(wake));

  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // A one-cycle pulse would be missed by a delayed sample, so latch it
  always @(posedge clk_sys_in) begin
    if (wake === 1'b1) wake_seen <= 1'b1;
  end

  // Ceiling is more than ten times the expected run length
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  function automatic logic [7:0] adr(input int idx);
    return 8'(CH * 4 + idx);
  endfunction

  // Whether an edge of the given polarity is captured in the current mode
  function automatic bit hit(input logic [2:0] m, input bit r, input int k);
    case (m)
      3'b001: return 1'b1;
      3'b010: return !r;
      3'b011: return r;
      3'b100: return r && (k % 4 == 0);
      3'b101: return r && (k % 16 == 0);
      default: return 1'b0;
    endcase
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_write_in <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
    #1 d = rdata;
  endtask

  // Control write also restarts the prescaler count
  task automatic setc(input logic [15:0] d);
    wr(adr(0), d);
    cm = d[2:0];
    ts = d[7];
    rcnt = 0;
  endtask

  // Fresh timer values, then one pin edge; timers hold through the capture
  task automatic pedge(input logic lvl);
    @(posedge clk_sys_in);
    ta <= 16'($random(seed));
    tb <= 16'($random(seed));
    #1 if (lvl) rcnt++;
    if (hit(cm, lvl, rcnt)) q.push_back(ts ? ta : tb);
    pin_drv.drive(lvl, 8);
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      pedge(1'b1);
      pedge(1'b0);
    end
  endtask

  task automatic drain();
    logic [15:0] d;
    rd(adr(0), d);
    chk(16'(d[3]), 16'(q.size() > 0));
    while (q.size() > 0) begin
      rd(adr(1), d);
      chk(d, q.pop_front());
    end
    rd(adr(0), d);
    chk(d & 16'h0018, 16'h0000);
  endtask

  task automatic clear_wake();
    @(posedge clk_sys_in);
    #1 wake_seen = 1'b0;
  endtask

  initial begin
    seed = 3375;
    reset_in = 1'b1;
    {reg_write_in, reg_read_in, cpu_sleep_in, cpu_idle_in, wake_seen} = '0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 16'h0000;
    ta = 16'h0000;
    tb = 16'h0000;
    repeat (8) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(adr(i), v);
      chk(v, 16'h0000);
    end
    chk(16'(irq), 16'h0000);
    setc(16'hffff);
    rd(adr(0), v);
    chk(v, 16'h20e7);
    wr(8'h00, 16'h0003);
    rd(8'h00, v);
    chk(v, 16'h0000);
    rd(adr(0), v);
    chk(v, 16'h20e7);
    $display("registers done");
    for (int m = 0; m < 7; m++) begin
      setc({8'h00, 1'($random(seed)), 4'h0, 3'(m)});
      n = (m == 5) ? 16 : (m == 4) ? 8 : 2;
      pulses(n);
      drain();
    end
    $display("modes done");
    setc(16'h0003);
    pulses(5);
    void'(q.pop_back());
    rd(adr(0), v);
    chk(v & 16'h0018, 16'h0018);
    rd(adr(2), v);
    chk(v, 16'h0003);
    drain();
    $display("overflow done");
    wr(adr(3), 16'h0001);
    for (int k = 0; k < 4; k++) begin
      setc({9'h000, 2'(k), 5'h03});
      for (int i = 0; i <= k; i++) begin
        pulses(1);
        chk(16'(irq), 16'(i == k));
      end
      rd(adr(2), v);
      chk(v, 16'h0001);
      repeat (2) @(posedge clk_sys_in);
      chk(16'(irq), 16'h0000);
      drain();
    end
    setc(16'h0061);
    pedge(1'b1);
    chk(16'(irq), 16'h0001);
    pedge(1'b0);
    rd(adr(2), v);
    chk(v, 16'h0001);
    drain();
    wr(adr(3), 16'h0000);
    setc(16'h0003);
    pulses(1);
    chk(16'(irq), 16'h0000);
    rd(adr(2), v);
    chk(v, 16'h0001);
    drain();
    $display("interrupts done");
    @(posedge clk_sys_in);
    cpu_idle_in <= 1'b1;
    setc(16'h2003);
    pulses(1);
    q.delete();
    rd(adr(0), v);
    chk(v & 16'h0018, 16'h0000);
    setc(16'h0003);
    clear_wake();
    pulses(1);
    chk(16'(wake_seen), 16'h0001);
    rd(adr(2), v);
    chk(v, 16'h0001);
    drain();
    @(posedge clk_sys_in);
    cpu_idle_in <= 1'b0;
    cpu_sleep_in <= 1'b1;
    wr(adr(3), 16'h0004);
    setc(16'h0007);
    clear_wake();
    pulses(1);
    chk(16'(wake_seen), 16'h0001);
    chk(16'(irq), 16'h0001);
    rd(adr(2), v);
    chk(v, 16'h0004);
    drain();
    $display("power done");
    conclude();
  end
endmodule
